// *** design/ucx_regs.svh ***
// Timing counts, size codes and reset values of the serial datapath
`ifndef UCX_REGS_SVH
`define UCX_REGS_SVH

// ****************************************************************
// Oversampling counts
// ****************************************************************
// Ticks of the oversampling strobe per bit are LAST + 1
`define UCX_OVS_LAST 4'hf
// Tick at which the start bit is checked a second time
`define UCX_OVS_MID 4'h7

// ****************************************************************
// Character sizes
// ****************************************************************
`define UCX_CSZ_NINE 3'h7
`define UCX_BITS_MIN 4'h5
`define UCX_BITS_EIGHT 4'h8
`define UCX_BITS_NINE 4'h9
`define UCX_MASK_ALL 9'h1ff

// ****************************************************************
// Reset values
// ****************************************************************
`define UCX_LINE_IDLE 1'b1
`define UCX_TXC_RST 1'b0
`define UCX_EMPTY_RST 1'b1

`endif

// *** design/ucx_pkg.sv ***
// Types shared by the serial datapath modules
package ucx_pkg;

  // Transmitter states
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_START = 3'b001,
    TX_DATA = 3'b010,
    TX_PAR = 3'b011,
    TX_STOP = 3'b100
  } ucx_tx_st_e;

  // Receiver states
  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_START = 3'b001,
    RX_DATA = 3'b010,
    RX_PAR = 3'b011,
    RX_STOP = 3'b100
  } ucx_rx_st_e;

  // One character, ninth bit on top
  typedef struct packed {
    logic ninth;
    logic [7:0] value;
  } ucx_char_s;

  // One received frame with the status that travels with it
  typedef struct packed {
    ucx_char_s chr;
    logic frame_error_flag;
    logic overrun_flag;
    logic parity_error_flag;
  } ucx_rx_frame_s;

  // Frame format and enables
  typedef struct packed {
    logic transmitter_enable;
    logic receiver_enable;
    logic parity_enable_bit;
    logic parity_odd;
    logic [2:0] char_size_sel;
    logic two_stop;
    logic sync_mode;
  } ucx_cfg_s;

  // Interrupt enables
  typedef struct packed {
    logic tx_buffer_empty_irq_en;
    logic tx_complete_irq_en;
    logic global_irq_en;
  } ucx_ien_s;

endpackage

// *** design/ucx_buf2.sv ***
// Two-entry receive buffer with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none

module ucx_buf2 (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic flush,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire ucx_pkg::ucx_rx_frame_s in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output ucx_pkg::ucx_rx_frame_s out_data
);
  import ucx_pkg::*;

  ucx_rx_frame_s s0_q, s0_d, s1_q, s1_d;
  logic v0_q, v0_d, v1_q, v1_d;

  // Head slot feeds the output straight from its flops
  assign out_data = s0_q;
  assign out_valid = v0_q;
  // Full only when the second slot holds a word
  assign in_ready = ~v1_q;

  // Pop moves slot 1 forward, push fills the first free slot
  always_comb begin
    s0_d = s0_q;
    s1_d = s1_q;
    v0_d = v0_q;
    v1_d = v1_q;
    if (v0_q && out_ready) begin
      s0_d = s1_q;
      v0_d = v1_q;
      v1_d = 1'b0;
    end
    if (in_valid && !v1_q) begin
      if (!v0_d) begin
        s0_d = in_data;
        v0_d = 1'b1;
      end else begin
        s1_d = in_data;
        v1_d = 1'b1;
      end
    end
    // Flush drops both words
    if (flush) begin
      v0_d = 1'b0;
      v1_d = 1'b0;
    end
  end

  // Registers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s0_q <= '0;
      s1_q <= '0;
      v0_q <= 1'b0;
      v1_q <= 1'b0;
    end else begin
      s0_q <= s0_d;
      s1_q <= s1_d;
      v0_q <= v0_d;
      v1_q <= v1_d;
    end
  end

endmodule
`default_nettype wire

// *** design/ucx_datapath.sv ***
// Serial port transmit and receive datapath
`timescale 1ns/1ns
`default_nettype none
`include "ucx_regs.svh"

module ucx_datapath (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Configuration and bit-rate strobe
  input wire ucx_pkg::ucx_cfg_s cfg,
  input wire ucx_pkg::ucx_ien_s ien,
  input wire logic ovs_tick,
  // Transmit data register
  input wire logic data_wr_en,
  input wire logic [7:0] data_wr,
  input wire logic tx_ninth_bit,
  input wire logic tx_complete_clr,
  input wire logic txc_irq_ack,
  // Receive data register
  input wire logic data_rd_en,
  output wire ucx_pkg::ucx_rx_frame_s rx_head,
  output wire logic rx_complete_flag,
  // Flags and interrupt requests
  output logic tx_buffer_empty_flag,
  output logic tx_complete_flag,
  output logic irq_tx_empty,
  output logic irq_tx_done,
  // Pins
  input wire logic serial_in_pin,
  input wire logic transfer_clock_pin,
  output logic serial_out_pin,
  output logic serial_out_en,
  output logic serial_in_sel
);
  import ucx_pkg::*;

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // Data bits per character from the size code
  function automatic logic [3:0] ucx_nbits(input logic [2:0] csz);
    logic [3:0] n;
    n = `UCX_BITS_EIGHT;
    if (csz == `UCX_CSZ_NINE) begin
      n = `UCX_BITS_NINE;
    end else if (csz[2] == 1'b0) begin
      n = `UCX_BITS_MIN + {2'b00, csz[1:0]};
    end
    return n;
  endfunction

  // Keeps the low n bits of a character
  function automatic logic [8:0] ucx_mask(input logic [8:0] c,
                                          input logic [3:0] n);
    logic [8:0] m;
    m = `UCX_MASK_ALL >> (`UCX_BITS_NINE - n);
    return c & m;
  endfunction

  // Parity of the used data bits, inverted when odd
  function automatic logic ucx_parity(input logic [8:0] c,
                                      input logic [3:0] n,
                                      input logic odd);
    return (^ucx_mask(c, n)) ^ odd;
  endfunction

  logic [3:0] nbits;
  logic xck_q, xck_d;
  logic xck_rise, xck_fall;
  logic rxd;

  assign nbits = ucx_nbits(cfg.char_size_sel);
  // Pin is synchronous to clk_sys, so one flop is enough for edges
  assign xck_d = transfer_clock_pin;
  assign xck_rise = transfer_clock_pin & ~xck_q;
  assign xck_fall = ~transfer_clock_pin & xck_q;
  // Disabled receiver sees an idle line
  assign rxd = cfg.receiver_enable ? serial_in_pin : `UCX_LINE_IDLE;

  // ****************************************************************
  // Transmitter
  // ****************************************************************

  ucx_tx_st_e tx_st_q, tx_st_d;
  ucx_char_s tbuf_q, tbuf_d;
  logic tbuf_empty_q, tbuf_empty_d;
  logic [8:0] tx_sh_q, tx_sh_d;
  logic [8:0] tx_chr_q, tx_chr_d;
  logic [3:0] tx_bidx_q, tx_bidx_d;
  logic [3:0] tx_cnt_q, tx_cnt_d;
  logic tx_stop2_q, tx_stop2_d;
  logic transmitter_enable_q, transmitter_enable_d;
  logic txc_q, txc_d;
  logic txd_q, txd_d;
  logic tx_tick, tx_load, tx_done, txc_set;

  // Bit period: every 16th strobe, or the falling transfer clock edge
  assign tx_tick = cfg.sync_mode ? xck_fall
                 : (ovs_tick && tx_cnt_q == `UCX_OVS_LAST);
  // Frame ends on the tick of the last stop bit
  assign tx_done = tx_st_q == TX_STOP && tx_tick
                 && !(cfg.two_stop && !tx_stop2_q);
  // Loading only on a bit boundary keeps the start bit full length
  assign tx_load = !tbuf_empty_q && transmitter_enable_q && tx_tick
                 && (tx_st_q == TX_IDLE || tx_done);
  // A write landing on the last stop tick leaves data behind: no complete
  assign txc_set = tx_done && !tx_load && tbuf_empty_d;

  // Next state of the transmit buffer, shifter and flags
  always_comb begin
    tx_st_d = tx_st_q;
    tbuf_d = tbuf_q;
    tbuf_empty_d = tbuf_empty_q;
    tx_sh_d = tx_sh_q;
    tx_chr_d = tx_chr_q;
    tx_bidx_d = tx_bidx_q;
    tx_stop2_d = tx_stop2_q;
    tx_cnt_d = ovs_tick ? tx_cnt_q + 4'h1 : tx_cnt_q;
    // Writes into a full buffer are dropped
    if (data_wr_en && tbuf_empty_q) begin
      tbuf_d = '{ninth: tx_ninth_bit, value: data_wr};
      tbuf_empty_d = 1'b0;
    end
    unique case (tx_st_q)
      TX_IDLE: begin
      end
      TX_START: begin
        if (tx_tick) begin
          tx_st_d = TX_DATA;
        end
      end
      TX_DATA: begin
        if (tx_tick) begin
          tx_sh_d = tx_sh_q >> 1;
          tx_bidx_d = tx_bidx_q + 4'h1;
          if (tx_bidx_q == nbits - 4'h1) begin
            tx_st_d = cfg.parity_enable_bit ? TX_PAR : TX_STOP;
            tx_stop2_d = 1'b0;
          end
        end
      end
      TX_PAR: begin
        if (tx_tick) begin
          tx_st_d = TX_STOP;
        end
      end
      TX_STOP: begin
        if (tx_tick) begin
          tx_stop2_d = 1'b1;
          if (tx_done) begin
            tx_st_d = TX_IDLE;
          end
        end
      end
    endcase
    // A new character enters the shifter, freeing the buffer
    if (tx_load) begin
      tx_st_d = TX_START;
      tx_sh_d = ucx_mask(tbuf_q, nbits);
      tx_chr_d = ucx_mask(tbuf_q, nbits);
      tx_bidx_d = 4'h0;
      tbuf_empty_d = 1'b1;
    end
  end

  // Flags, deferred disable and the line level
  always_comb begin
    // Set wins over both ways of clearing
    txc_d = txc_q;
    if (txc_irq_ack || tx_complete_clr) begin
      txc_d = 1'b0;
    end
    if (txc_set) begin
      txc_d = 1'b1;
    end
    // Enable drops only once nothing is left to send
    transmitter_enable_d = transmitter_enable_q;
    if (cfg.transmitter_enable) begin
      transmitter_enable_d = 1'b1;
    end else if (tx_st_d == TX_IDLE && tbuf_empty_d) begin
      transmitter_enable_d = 1'b0;
    end
    // Line level follows the next state so it lines up with it
    unique case (tx_st_d)
      TX_START: txd_d = 1'b0;
      TX_DATA: txd_d = tx_sh_d[0];
      TX_PAR: txd_d = ucx_parity(tx_chr_d, nbits, cfg.parity_odd);
      default: txd_d = `UCX_LINE_IDLE;
    endcase
  end

  // Transmitter registers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tx_st_q <= TX_IDLE;
      tbuf_q <= '0;
      tbuf_empty_q <= `UCX_EMPTY_RST;
      tx_sh_q <= '0;
      tx_chr_q <= '0;
      tx_bidx_q <= 4'h0;
      tx_cnt_q <= 4'h0;
      tx_stop2_q <= 1'b0;
      transmitter_enable_q <= 1'b0;
      txc_q <= `UCX_TXC_RST;
      txd_q <= `UCX_LINE_IDLE;
      xck_q <= 1'b0;
    end else begin
      tx_st_q <= tx_st_d;
      tbuf_q <= tbuf_d;
      tbuf_empty_q <= tbuf_empty_d;
      tx_sh_q <= tx_sh_d;
      tx_chr_q <= tx_chr_d;
      tx_bidx_q <= tx_bidx_d;
      tx_cnt_q <= tx_cnt_d;
      tx_stop2_q <= tx_stop2_d;
      transmitter_enable_q <= transmitter_enable_d;
      txc_q <= txc_d;
      txd_q <= txd_d;
      xck_q <= xck_d;
    end
  end

  // ****************************************************************
  // Receiver
  // ****************************************************************

  ucx_rx_st_e rx_st_q, rx_st_d;
  logic [8:0] rx_sh_q, rx_sh_d;
  logic [3:0] rx_bidx_q, rx_bidx_d;
  logic [3:0] rx_cnt_q, rx_cnt_d;
  logic rx_par_q, rx_par_d;
  logic lost_q, lost_d;
  logic pend_v_q, pend_v_d;
  ucx_rx_frame_s pend_q, pend_d;
  logic buf_ready, rx_samp, pend_free;

  // Mid-bit sample, or the rising transfer clock edge
  assign rx_samp = cfg.sync_mode ? xck_rise
                 : (ovs_tick && rx_cnt_q == `UCX_OVS_LAST);
  // A frame that ends while the previous one still waits on a full buffer is lost
  assign pend_free = !pend_v_q || buf_ready;

  // Next state of the receive shifter and the waiting frame
  always_comb begin
    rx_st_d = rx_st_q;
    rx_sh_d = rx_sh_q;
    rx_bidx_d = rx_bidx_q;
    rx_par_d = rx_par_q;
    lost_d = lost_q;
    pend_d = pend_q;
    pend_v_d = pend_v_q && !buf_ready;
    rx_cnt_d = ovs_tick ? rx_cnt_q + 4'h1 : rx_cnt_q;
    unique case (rx_st_q)
      RX_IDLE: begin
        rx_sh_d = 9'h000;
        rx_bidx_d = 4'h0;
        rx_cnt_d = 4'h0;
        if (!rxd && (cfg.sync_mode ? xck_rise : ovs_tick)) begin
          rx_st_d = cfg.sync_mode ? RX_DATA : RX_START;
        end
      end
      RX_START: begin
        // Start bit must still be low half a bit later
        if (ovs_tick && rx_cnt_q == `UCX_OVS_MID) begin
          rx_cnt_d = 4'h0;
          rx_st_d = rxd ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA: begin
        if (rx_samp) begin
          rx_sh_d[rx_bidx_q] = rxd;
          rx_bidx_d = rx_bidx_q + 4'h1;
          if (rx_bidx_q == nbits - 4'h1) begin
            rx_st_d = cfg.parity_enable_bit ? RX_PAR : RX_STOP;
          end
        end
      end
      RX_PAR: begin
        if (rx_samp) begin
          rx_par_d = rxd;
          rx_st_d = RX_STOP;
        end
      end
      RX_STOP: begin
        // Only the first stop bit is looked at
        if (rx_samp) begin
          rx_st_d = RX_IDLE;
          if (pend_free) begin
            pend_v_d = 1'b1;
            pend_d.chr = ucx_char_s'(rx_sh_q);
            pend_d.frame_error_flag = !rxd;
            pend_d.overrun_flag = lost_q;
            pend_d.parity_error_flag = cfg.parity_enable_bit
              && (rx_par_q != ucx_parity(rx_sh_q, nbits, cfg.parity_odd));
            lost_d = 1'b0;
          end else begin
            lost_d = 1'b1;
          end
        end
      end
      default: rx_st_d = RX_IDLE;
    endcase
    // Disabling is immediate and drops everything in flight
    if (!cfg.receiver_enable) begin
      rx_st_d = RX_IDLE;
      pend_v_d = 1'b0;
      lost_d = 1'b0;
    end
  end

  // Receiver registers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rx_st_q <= RX_IDLE;
      rx_sh_q <= 9'h000;
      rx_bidx_q <= 4'h0;
      rx_cnt_q <= 4'h0;
      rx_par_q <= 1'b0;
      lost_q <= 1'b0;
      pend_v_q <= 1'b0;
      pend_q <= '0;
    end else begin
      rx_st_q <= rx_st_d;
      rx_sh_q <= rx_sh_d;
      rx_bidx_q <= rx_bidx_d;
      rx_cnt_q <= rx_cnt_d;
      rx_par_q <= rx_par_d;
      lost_q <= lost_d;
      pend_v_q <= pend_v_d;
      pend_q <= pend_d;
    end
  end

  // Two-entry FIFO; a read of the data register advances it
  ucx_buf2 u_rx_fifo (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .flush(!cfg.receiver_enable),
    .in_valid(pend_v_q),
    .in_ready(buf_ready),
    .in_data(pend_q),
    .out_valid(rx_complete_flag),
    .out_ready(data_rd_en),
    .out_data(rx_head)
  );

  // ****************************************************************
  // Outputs
  // ****************************************************************

  // Registered copies so every output comes from a flop
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tx_buffer_empty_flag <= `UCX_EMPTY_RST;
      tx_complete_flag <= `UCX_TXC_RST;
      irq_tx_empty <= 1'b0;
      irq_tx_done <= 1'b0;
      serial_out_pin <= `UCX_LINE_IDLE;
      serial_out_en <= 1'b0;
      serial_in_sel <= 1'b0;
    end else begin
      tx_buffer_empty_flag <= tbuf_empty_d;
      tx_complete_flag <= txc_d;
      irq_tx_empty <= ien.tx_buffer_empty_irq_en && ien.global_irq_en
                      && tbuf_empty_d;
      irq_tx_done <= ien.tx_complete_irq_en && ien.global_irq_en
                     && txc_d;
      serial_out_pin <= txd_d;
      serial_out_en <= transmitter_enable_d;
      serial_in_sel <= cfg.receiver_enable;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_data_end;
    tx_st_q == TX_DATA ##1 tx_st_q != TX_DATA;
  endsequence

  a_wr_clears_empty: assert property (data_wr_en && tx_buffer_empty_flag
    && !tx_load |=> !tx_buffer_empty_flag)
    else $error("buffer-empty flag not cleared by write");
  a_empty_irq_level: assert property ($past(!sys_rst) |-> irq_tx_empty ==
    ($past(ien.tx_buffer_empty_irq_en && ien.global_irq_en)
     && tx_buffer_empty_flag))
    else $error("buffer-empty request wrong");
  a_txc_set_done: assert property (txc_set |=> tx_complete_flag
    ##0 serial_out_pin && tx_buffer_empty_flag)
    else $error("transmit-complete not set after frame");
  a_txc_clear_ack: assert property (tx_complete_flag && !txc_set
    && (txc_irq_ack || tx_complete_clr) |=> !tx_complete_flag)
    else $error("transmit-complete not cleared");
  a_txc_irq_rise: assert property ($rose(tx_complete_flag)
    && $past(ien.tx_complete_irq_en && ien.global_irq_en) |-> irq_tx_done)
    else $error("transmit-complete request missing");
  a_par_slot: assert property (s_data_end |->
    (tx_st_q == TX_PAR) == cfg.parity_enable_bit)
    else $error("parity slot wrong");
  a_par_value: assert property (tx_st_q == TX_PAR |-> serial_out_pin ==
    ((^tx_chr_q) ^ cfg.parity_odd))
    else $error("parity bit value wrong");
  a_transmitter_enable_defer: assert property ($fell(serial_out_en) |->
    tx_st_q == TX_IDLE && tx_buffer_empty_flag)
    else $error("transmitter disabled with data left");
  a_tx_load_idle: assert property (tx_st_q == TX_IDLE && tx_load
    |=> tx_st_q == TX_START ##0 !serial_out_pin)
    else $error("buffered data not loaded");
  a_rx_flush: assert property (!cfg.receiver_enable |=>
    !rx_complete_flag)
    else $error("receive buffer not flushed");
  a_rx_store: assert property (rx_st_q == RX_STOP && rx_samp
    && pend_free && cfg.receiver_enable |=> pend_v_q)
    else $error("frame not stored after stop bit");
  a_rx_upper_zero: assert property (rx_complete_flag
    && $stable(cfg.char_size_sel) |-> ucx_mask(rx_head.chr, nbits) ==
    rx_head.chr)
    else $error("unused data bits not zero");

endmodule
`default_nettype wire

// *** testbench/ucx_node.sv ***
// Remote serial node facing the datapath pins
`timescale 1ns/1ns
`default_nettype none
module ucx_node (
  // Clock
  input wire logic clk_sys,
  // Frame format shared with the device
  input wire logic [3:0] nb,
  input wire logic pe,
  // Line from the device
  input wire logic line_in,
  input wire logic line_en,
  // Line to the device
  output logic line_out
);
  // ****************************************************************
  // Capture and send
  // ****************************************************************
  int bt = 32;
  logic [11:0] got[$];
  logic [11:0] raw;
  initial line_out = 1'b1;
  // Mid-bit sampling; first data bit lands in bit 0
  always begin
    @(negedge line_in);
    if (line_en) begin
      repeat (bt / 2) @(posedge clk_sys);
      raw = '0;
      for (int i = 0; i <= nb + pe; i++) begin
        repeat (bt) @(posedge clk_sys);
        raw[i] = line_in;
      end
      got.push_back(raw);
    end
  end
  // A broken stop is kept short so it cannot pass for a start
  task automatic send(input logic [8:0] d, input int n, input int par,
                      input logic stop);
    line_out = 1'b0;
    repeat (bt) @(negedge clk_sys);
    for (int i = 0; i < n; i++) begin
      line_out = d[i];
      repeat (bt) @(negedge clk_sys);
    end
    if (par >= 0) begin
      line_out = par[0];
      repeat (bt) @(negedge clk_sys);
    end
    line_out = stop;
    repeat (bt / 2 + 4) @(negedge clk_sys);
    line_out = 1'b1;  // Idle level between frames
    repeat (2 * bt) @(negedge clk_sys);
  endtask
endmodule
`default_nettype wire

// *** testbench/ucx_datapath_bench.sv ***
// Self-checking bench of the serial transmit and receive datapath
`timescale 1ns/1ns
`default_nettype none
module ucx_datapath_bench;
  import ucx_pkg::*;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  ucx_cfg_s cfg = 9'h1cc;  // Both enabled, even parity, 8 bits
  ucx_ien_s ien = 3'h7;
  logic ovs_tick = 1'b0;
  logic data_wr_en = 1'b0, tx_ninth_bit = 1'b0, tx_complete_clr = 1'b0;
  logic txc_irq_ack = 1'b0, data_rd_en = 1'b0;
  logic [7:0] data_wr = 8'h00;
  ucx_rx_frame_s rx_head;
  logic rx_complete_flag, tx_buffer_empty_flag, tx_complete_flag;
  logic irq_tx_empty, irq_tx_done, serial_out_pin, serial_out_en;
  logic serial_in_sel, node_line;
  logic xck = 1'b0, xck_on = 1'b0;
  int xck_div = 0;
  logic [3:0] nb;
  int errors = 0, cmp_count = 0;
  ucx_rx_frame_s exp_q[$];
  int sizes[6] = '{0, 1, 2, 3, 4, 7};
  always #50 clk_sys = ~clk_sys;
  // Strobe every other cycle: one bit lasts 32 cycles
  always @(negedge clk_sys) ovs_tick <= ~ovs_tick;
  // Transfer clock of 32 cycles, held low while switched off
  always @(negedge clk_sys) begin
    xck_div <= (xck_div + 1) % 16;
    if (xck_div == 15)
      xck <= xck_on & ~xck;
  end
  function automatic int nbits(logic [2:0] s);
    return s < 4 ? s + 5 : (s == 7 ? 9 : 8);
  endfunction
  assign nb = 4'(nbits(cfg.char_size_sel));
  ucx_datapath i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .cfg(cfg),
    .ien(ien), .ovs_tick(ovs_tick), .data_wr_en(data_wr_en),
    .data_wr(data_wr), .tx_ninth_bit(tx_ninth_bit),
    .tx_complete_clr(tx_complete_clr), .txc_irq_ack(txc_irq_ack),
    .data_rd_en(data_rd_en), .rx_head(rx_head),
    .rx_complete_flag(rx_complete_flag),
    .tx_buffer_empty_flag(tx_buffer_empty_flag),
    .tx_complete_flag(tx_complete_flag), .irq_tx_empty(irq_tx_empty),
    .irq_tx_done(irq_tx_done), .serial_in_pin(node_line),
    .transfer_clock_pin(xck), .serial_out_pin(serial_out_pin),
    .serial_out_en(serial_out_en), .serial_in_sel(serial_in_sel));
  ucx_node i_node (.clk_sys(clk_sys), .nb(nb),
    .pe(cfg.parity_enable_bit), .line_in(serial_out_pin),
    .line_en(serial_out_en), .line_out(node_line));
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic check(input string nm, input logic [11:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("Checks %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Bounded wait so a stuck flag cannot hang the run
  task automatic wait_hi(ref logic s, input string nm);
    for (int i = 0; i < 3000 && s !== 1'b1; i++)
      @(negedge clk_sys);
    check(nm, s, 1);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk_sys);
    s = 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic tx_write(input logic [8:0] d);
    tx_ninth_bit = d[8];
    data_wr = d[7:0];
    data_wr_en = 1'b1;
    @(negedge clk_sys);
    data_wr_en = 1'b0;
  endtask
  task automatic tx_cmp(input logic [8:0] d);
    int n;
    logic [11:0] e;
    n = nbits(cfg.char_size_sel);
    e = 12'(d & (9'h1ff >> (9 - n)));
    if (cfg.parity_enable_bit)
      e[n] = ^e ^ cfg.parity_odd;
    e[n + cfg.parity_enable_bit] = 1'b1;
    check("tx_frame", i_node.got.pop_front(), e);
  endtask
  task automatic tx_one(input logic [8:0] d, input int k);
    tx_write(d);
    check("empty_flag", tx_buffer_empty_flag, 0);
    wait_hi(tx_complete_flag, "tx_complete");
    @(negedge clk_sys);
    check("irq_tx_done", irq_tx_done, 1);
    tx_cmp(d);
    if (k % 2)
      pulse(txc_irq_ack);
    else
      pulse(tx_complete_clr);
    check("complete_clr", tx_complete_flag, 0);
  endtask
  task automatic rx_one(input logic [8:0] d, input logic pbad, fbad, ovr,
                        input bit keep);
    int n;
    logic [8:0] m;
    n = nbits(cfg.char_size_sel);
    m = d & (9'h1ff >> (9 - n));
    i_node.send(m, n, cfg.parity_enable_bit ?
                int'(^m ^ cfg.parity_odd ^ pbad) : -1, !fbad);
    if (keep)
      exp_q.push_back(ucx_rx_frame_s'({m, fbad, ovr,
                      pbad & cfg.parity_enable_bit}));
  endtask
  task automatic rx_read();
    wait_hi(rx_complete_flag, "rx_complete");
    check("rx_head", rx_head, exp_q.pop_front());
    pulse(data_rd_en);
  endtask
  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    void'($urandom(32'h0e42));
    repeat (12) @(negedge clk_sys);
    check("rst_empty", tx_buffer_empty_flag, 1);
    check("rst_line", serial_out_pin, 1);
    sys_rst = 1'b0;
    repeat (2) @(negedge clk_sys);
    check("irq_empty_on", irq_tx_empty, 1);
    check("in_sel_on", serial_in_sel, 1);
    ien.global_irq_en = 1'b0;
    repeat (2) @(negedge clk_sys);
    check("irq_empty_off", irq_tx_empty, 0);
    ien.global_irq_en = 1'b1;
    // Size codes 0-4 and 7; parity off once, sense random
    foreach (sizes[k]) begin
      cfg.char_size_sel = 3'(sizes[k]);
      cfg.parity_enable_bit = (k != 0);
      cfg.parity_odd = 1'($urandom);
      tx_one(9'($urandom), k);
    end
    // Second character queued while the first is on the line
    tx_write(9'h0a5);
    wait_hi(tx_buffer_empty_flag, "loaded");
    tx_write(9'h15a);
    wait_hi(tx_complete_flag, "b2b_done");
    check("b2b_frames", 12'(i_node.got.size()), 2);
    tx_cmp(9'h0a5);
    tx_cmp(9'h15a);
    // Clearing complete leaves the buffer-empty flag untouched
    pulse(tx_complete_clr);
    // Disable mid-frame: the pin stays owned until the frame ends
    tx_write(9'h1c3);
    repeat (150) @(negedge clk_sys);
    cfg.transmitter_enable = 1'b0;
    repeat (2) @(negedge clk_sys);
    check("out_en_held", serial_out_en, 1);
    wait_hi(tx_complete_flag, "off_done");
    repeat (3) @(negedge clk_sys);
    check("out_en_off", serial_out_en, 0);
    tx_cmp(9'h1c3);
    pulse(tx_complete_clr);
    cfg.transmitter_enable = 1'b1;
    // Received sizes; a parity fault and a stop fault among them
    foreach (sizes[k]) begin
      cfg.char_size_sel = 3'(sizes[k]);
      rx_one(9'($urandom), k == 1, k == 2, 0, 1);
      rx_read();
    end
    // Four without a read: the fourth is lost, the next one tells
    for (int k = 0; k < 4; k++)
      rx_one(9'(k + 9'h130), 0, 0, 0, k < 3);
    repeat (3) rx_read();
    rx_one(9'h0c7, 0, 0, 1, 1);
    rx_read();
    // Receiver off with a character waiting, then traffic ignored
    rx_one(9'h055, 0, 0, 0, 0);
    wait_hi(rx_complete_flag, "rx_wait");
    cfg.receiver_enable = 1'b0;
    repeat (3) @(negedge clk_sys);
    check("flushed", rx_complete_flag, 0);
    check("in_sel_off", serial_in_sel, 0);
    rx_one(9'h0aa, 0, 0, 0, 0);
    check("rx_ignored", rx_complete_flag, 0);
    cfg.receiver_enable = 1'b1;
    // Synchronous mode on the transfer clock, two stop bits sent
    cfg.sync_mode = 1'b1;
    cfg.two_stop = 1'b1;
    xck_on = 1'b1;
    tx_one(9'($urandom), 1);
    rx_one(9'($urandom), 0, 0, 0, 1);
    rx_read();
    summarize();
  end
  // Watchdog far beyond the expected run of about 9500 cycles
  initial begin
    repeat (60000) @(posedge clk_sys);
    errors++;
    summarize();
  end
endmodule
`default_nettype wire
